// ===== rtl/acs_status.sv
/*
  Status and mode logic of channel A, channel B and the codec command channel
  of an AC97 link controller, reached over AHB-Lite.
  Assumes the slot engine drives request, receive and bit clock levels from the
  link domain, and the DMA engine drives counters and their write strobes on
  i_sys_clk.
*/
// The implementer's own choice: the AHB-Lite register port.
// Summary of operation
// - A tx buffer empty when both counters zero
// - A end-of-rx on zero, cleared by write
// - A rx buffer full when both counters zero
// - B end-of-tx on zero, cleared by write
// - B tx buffer empty when both counters zero
// - B end-of-rx on zero, cleared by write
// - B rx buffer full when both counters zero
// - transmit ready low from load until moved
// - transmit empty only after word fully sent
// - underrun only with variable rate mode
// - underrun when sample requested without data
// - underrun and overrun cleared by status read
// - receive ready while holding register full
// - overrun when unread word is overwritten
// - codec channel has its own status register
// - mode bits enable each channel A flag
// - samples MSB-justified, low bits zero-filled
// - endian bit byte-swaps memory data
// - channel A moves data only when enabled
// - channel A DMA flags only generated with DMA use
// - channel event while flags and enables overlap
`timescale 1ns/1ns
`include "acs_cfg.svh"

module acs_status
  import acs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output var  logic [31:0] o_hrdata,
  output var  logic        o_hreadyout,
  output var  logic        o_hresp,
  input  wire logic        i_variable_rate_mode,
  input  wire logic [15:0] i_chan_a_tx_counter,
  input  wire logic [15:0] i_chan_a_tx_next_counter,
  input  wire logic [15:0] i_chan_a_rx_counter,
  input  wire logic [15:0] i_chan_a_rx_next_counter,
  input  wire logic [15:0] i_chan_b_tx_counter,
  input  wire logic [15:0] i_chan_b_tx_next_counter,
  input  wire logic [15:0] i_chan_b_rx_counter,
  input  wire logic [15:0] i_chan_b_rx_next_counter,
  input  wire logic        i_chan_a_tx_counter_wr,
  input  wire logic        i_chan_a_rx_counter_wr,
  input  wire logic        i_chan_b_tx_counter_wr,
  input  wire logic        i_chan_b_rx_counter_wr,
  input  wire logic        i_bit_clk,
  input  wire logic [2:0]  i_slot_req,
  input  wire logic [2:0]  i_slot_rx,
  input  wire logic [19:0] i_rx_word,
  output var  logic [19:0] o_tx_word,
  output var  logic        o_tx_word_valid,
  output var  logic [1:0]  o_tx_chan,
  output var  logic        o_chan_a_event
);

  acs_state_t       st_ff;
  acs_state_t       nxt_st;
  logic [15:0]      stat_a;
  logic [15:0]      stat_b;
  logic [15:0]      stat_co;
  logic [2:0]       req_pulse;
  logic [2:0]       rx_pulse;
  logic [2:0]       chan_on;
  logic             bclk_rise;
  logic             rd_take;
  logic [3:0][15:0] cur_cnt;
  logic [3:0][15:0] nxt_cnt;
  logic [3:0]       cnt_wr;

  // flags shared by all three channels
  function automatic logic [15:0] base_flags(input logic       full,
                                             input logic [4:0] shcnt,
                                             input logic       ur,
                                             input logic       rr,
                                             input logic       ovr);
    base_flags = 16'h0000;
    base_flags[`ACS_BIT_TRANSMIT_READY]   = ~full;
    base_flags[`ACS_BIT_TRANSMIT_EMPTY] = ~full & (shcnt == 5'h00);
    base_flags[`ACS_BIT_TRANSMIT_UNDERRUN]   = ur;
    base_flags[`ACS_BIT_RECEIVE_READY]   = rr;
    base_flags[`ACS_BIT_RECEIVE_OVERRUN]   = ovr;
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] d);
    swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  function automatic logic [19:0] justify(input logic [19:0] d, input logic [1:0] size);
    unique case (size)
      `ACS_SIZE_20: justify = d;
      `ACS_SIZE_18: justify = {d[17:0], 2'h0};
      `ACS_SIZE_16: justify = {d[15:0], 4'h0};
      `ACS_SIZE_10: justify = {d[9:0], 10'h000};
    endcase
  endfunction

  assign cur_cnt   = {i_chan_b_rx_counter, i_chan_b_tx_counter, i_chan_a_rx_counter, i_chan_a_tx_counter};
  assign nxt_cnt   = {i_chan_b_rx_next_counter, i_chan_b_tx_next_counter,
                      i_chan_a_rx_next_counter, i_chan_a_tx_next_counter};
  assign cnt_wr    = {i_chan_b_rx_counter_wr, i_chan_b_tx_counter_wr,
                      i_chan_a_rx_counter_wr, i_chan_a_tx_counter_wr};
  assign req_pulse = st_ff.req_s2 & ~st_ff.req_q;
  assign rx_pulse  = st_ff.rx_s2 & ~st_ff.rx_q;
  assign bclk_rise = st_ff.bclk_s[1] & ~st_ff.bclk_q;
  // channel A gated by its enable bit
  assign chan_on   = {2'h3, st_ff.mode_a[`ACS_BIT_CEN]};
  assign rd_take   = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;

  // codec channel has only the common flags
  assign stat_co = base_flags(st_ff.hold_full[2], st_ff.shift_cnt[2], st_ff.transmit_underrun[2],
                              st_ff.rx_rdy[2], st_ff.receive_overrun[2]);

  always_comb
  begin
    stat_a = base_flags(st_ff.hold_full[0], st_ff.shift_cnt[0], st_ff.transmit_underrun[0],
                        st_ff.rx_rdy[0], st_ff.receive_overrun[0]);
    stat_a[`ACS_BIT_A_END_OF_TRANSMISSION]  = st_ff.end_flag[0];
    stat_a[`ACS_BIT_A_TX_BUFFER_EMPTY] = st_ff.buf_flag[0];
    stat_a[`ACS_BIT_END_OF_RECEPTION]    = st_ff.end_flag[1];
    stat_a[`ACS_BIT_RX_BUFFER_FULL]   = st_ff.buf_flag[1];
    stat_b = base_flags(st_ff.hold_full[1], st_ff.shift_cnt[1], st_ff.transmit_underrun[1],
                        st_ff.rx_rdy[1], st_ff.receive_overrun[1]);
    stat_b[`ACS_BIT_B_END_OF_TRANSMISSION]  = st_ff.end_flag[2];
    stat_b[`ACS_BIT_B_TX_BUFFER_EMPTY] = st_ff.buf_flag[2];
    stat_b[`ACS_BIT_END_OF_RECEPTION]    = st_ff.end_flag[3];
    stat_b[`ACS_BIT_RX_BUFFER_FULL]   = st_ff.buf_flag[3];
  end

  always_comb
  begin
    logic        zero;
    logic [31:0] a_wdata;
    zero    = 1'b0;
    a_wdata = 32'h00000000;
    nxt_st  = st_ff;
    nxt_st.tx_word_valid = 1'b0;

    // link levels cross on two flops before anything looks at them
    nxt_st.bclk_s = {st_ff.bclk_s[0], i_bit_clk};
    nxt_st.bclk_q = st_ff.bclk_s[1];
    nxt_st.req_s1 = i_slot_req;
    nxt_st.req_s2 = st_ff.req_s1;
    nxt_st.req_q  = st_ff.req_s2;
    nxt_st.rx_s1  = i_slot_rx;
    nxt_st.rx_s2  = st_ff.rx_s1;
    nxt_st.rx_q   = st_ff.rx_s2;
    nxt_st.rxw_s1 = i_rx_word;
    nxt_st.rxw_s2 = st_ff.rxw_s1;

    // address phase: registered read data, clears come before any set
    nxt_st.wr_pend = i_hsel & i_htrans[1] & i_hready & i_hwrite;
    nxt_st.wr_addr = i_haddr;
    nxt_st.hrdata  = `ACS_RD_NONE;
    if (rd_take)
    begin
      unique case (i_haddr)
        `ACS_ADDR_A_RXH:
        begin
          // swap back on the way to memory
          nxt_st.hrdata = st_ff.mode_a[`ACS_BIT_CEM] ? swap32({12'h000, st_ff.rx_data[0]})
                                                      : {12'h000, st_ff.rx_data[0]};
          nxt_st.rx_rdy[0] = 1'b0;
        end
        `ACS_ADDR_B_RXH:
        begin
          nxt_st.hrdata    = {12'h000, st_ff.rx_data[1]};
          nxt_st.rx_rdy[1] = 1'b0;
        end
        `ACS_ADDR_CO_RXH:
        begin
          nxt_st.hrdata    = {12'h000, st_ff.rx_data[2]};
          nxt_st.rx_rdy[2] = 1'b0;
        end
        `ACS_ADDR_A_STAT:
        begin
          nxt_st.hrdata   = {16'h0000, stat_a};
          nxt_st.transmit_underrun[0] = 1'b0;
          nxt_st.receive_overrun[0] = 1'b0;
        end
        `ACS_ADDR_B_STAT:
        begin
          nxt_st.hrdata   = {16'h0000, stat_b};
          nxt_st.transmit_underrun[1] = 1'b0;
          nxt_st.receive_overrun[1] = 1'b0;
        end
        `ACS_ADDR_CO_STAT:
        begin
          nxt_st.hrdata   = {16'h0000, stat_co};
          nxt_st.transmit_underrun[2] = 1'b0;
          nxt_st.receive_overrun[2] = 1'b0;
        end
        `ACS_ADDR_A_MODE: nxt_st.hrdata = {9'h000, st_ff.mode_a};
        default:          nxt_st.hrdata = `ACS_RD_NONE;
      endcase
    end

    for (int c = 0; c < 3; c++)
    begin
      // shift register busy for one slot of bit clocks
      if (bclk_rise && (st_ff.shift_cnt[c] != 5'h00))
        nxt_st.shift_cnt[c] = st_ff.shift_cnt[c] - 5'h01;
      if (req_pulse[c] && chan_on[c])
      begin
        nxt_st.tx_word_valid = 1'b1;
        nxt_st.tx_chan       = acs_chan_t'(c[1:0]);
        if (st_ff.hold_full[c])
        begin
          // ready again once the word moves on
          nxt_st.tx_word      = st_ff.hold_data[c];
          nxt_st.hold_full[c] = 1'b0;
          nxt_st.shift_cnt[c] = `ACS_SLOT_BITS;
        end
        else
        begin
          nxt_st.tx_word = 20'h00000;
          if (i_variable_rate_mode)
            nxt_st.transmit_underrun[c] = 1'b1;
        end
      end
      if (rx_pulse[c] && chan_on[c])
      begin
        if (nxt_st.rx_rdy[c])
          nxt_st.receive_overrun[c] = 1'b1;
        nxt_st.rx_rdy[c]  = 1'b1;
        nxt_st.rx_data[c] = st_ff.rxw_s2;
      end
    end

    // a counter write clears the end flag, reaching zero in that cycle wins
    for (int k = 0; k < 4; k++)
    begin
      zero = (cur_cnt[k] == 16'h0000);
      nxt_st.cur_zero_q[k] = zero;
      if (cnt_wr[k])
        nxt_st.end_flag[k] = 1'b0;
      if (zero && !st_ff.cur_zero_q[k])
        nxt_st.end_flag[k] = 1'b1;
      nxt_st.buf_flag[k] = zero && (nxt_cnt[k] == 16'h0000);
      // no dma flags for channel A without dma use
      if ((k < 2) && !st_ff.mode_a[`ACS_BIT_CHANNEL_DMA_USE])
      begin
        nxt_st.end_flag[k] = 1'b0;
        nxt_st.buf_flag[k] = 1'b0;
      end
    end

    // data phase writes; a load after a move in the same cycle keeps the new word
    a_wdata = st_ff.mode_a[`ACS_BIT_CEM] ? swap32(i_hwdata) : i_hwdata;
    if (st_ff.wr_pend)
    begin
      unique case (st_ff.wr_addr)
        `ACS_ADDR_A_MODE: nxt_st.mode_a = i_hwdata[22:0] & `ACS_MODE_WMASK;
        `ACS_ADDR_A_TXH:
        begin
          nxt_st.hold_full[0] = 1'b1;
          nxt_st.hold_data[0] = justify(a_wdata[19:0], st_ff.mode_a[`ACS_BIT_SIZE +: 2]);
        end
        `ACS_ADDR_B_TXH:
        begin
          nxt_st.hold_full[1] = 1'b1;
          nxt_st.hold_data[1] = justify(i_hwdata[19:0], `ACS_SIZE_20);
        end
        `ACS_ADDR_CO_TXH:
        begin
          nxt_st.hold_full[2] = 1'b1;
          nxt_st.hold_data[2] = i_hwdata[19:0];
        end
        default: nxt_st.mode_a = st_ff.mode_a;
      endcase
    end

    nxt_st.event_a = |(stat_a & st_ff.mode_a[15:0]);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      st_ff           <= '0;
      st_ff.mode_a    <= `ACS_MODE_RST;
      st_ff.hreadyout <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign o_hrdata        = st_ff.hrdata;
  assign o_hreadyout     = st_ff.hreadyout;
  assign o_hresp         = st_ff.hresp;
  assign o_tx_word       = st_ff.tx_word;
  assign o_tx_word_valid = st_ff.tx_word_valid;
  assign o_tx_chan       = st_ff.tx_chan;
  assign o_chan_a_event  = st_ff.event_a;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  a_a_tx_buffer_empty_set:
    assert property (st_ff.mode_a[`ACS_BIT_CHANNEL_DMA_USE] && (i_chan_a_tx_counter == 16'h0000) &&
                     (i_chan_a_tx_next_counter == 16'h0000) |=> st_ff.buf_flag[0])
      else $error("channel A tx buffer empty not set");

  a_a_end_of_reception_clr:
    assert property (i_chan_a_rx_counter_wr && !((i_chan_a_rx_counter == 16'h0000) && !st_ff.cur_zero_q[1])
                     |=> !st_ff.end_flag[1])
      else $error("channel A end of reception not cleared by write");

  a_a_rx_buffer_full_clr:
    assert property ((i_chan_a_rx_counter != 16'h0000) |=> !st_ff.buf_flag[1])
      else $error("channel A rx buffer full with nonzero counter");

  a_b_end_of_transmission_set:
    assert property ((i_chan_b_tx_counter == 16'h0000) && !st_ff.cur_zero_q[2] |=> st_ff.end_flag[2])
      else $error("channel B end of transmission missed");

  a_transmit_ready_load:
    assert property (st_ff.wr_pend && (st_ff.wr_addr == `ACS_ADDR_A_TXH) |=> !stat_a[`ACS_BIT_TRANSMIT_READY])
      else $error("transmit ready high after load");

  a_transmit_empty_slot:
    assert property ($rose(st_ff.shift_cnt[1] != 5'h00) |-> !stat_b[`ACS_BIT_TRANSMIT_EMPTY] [*8])
      else $error("transmit empty while word is still shifting");

  a_transmit_underrun_vra:
    assert property (!i_variable_rate_mode && !st_ff.transmit_underrun[1] |=> !st_ff.transmit_underrun[1])
      else $error("underrun raised without variable rate mode");

  a_cor_clear:
    assert property (rd_take && (i_haddr == `ACS_ADDR_CO_STAT) && !req_pulse[2] && !rx_pulse[2]
                     |=> !st_ff.transmit_underrun[2] && !st_ff.receive_overrun[2])
      else $error("codec flags not cleared by status read");

  a_receive_overrun_set:
    assert property (rx_pulse[2] && st_ff.rx_rdy[2] && !rd_take |=> st_ff.receive_overrun[2] && st_ff.rx_rdy[2])
      else $error("overrun not flagged on overwrite");

  a_event_a:
    assert property (|(stat_a & st_ff.mode_a[15:0]) |=> o_chan_a_event)
      else $error("channel A event missing");

endmodule

// ===== rtl/acs_cfg.svh
/*
  Addresses, field positions, reset values and slot timing for the audio
  channel status and mode block. Assumes a 32-bit AHB-Lite address space
  with every register on an aligned word.
*/
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_ADDR_A_RXH   32'hFFFAC020
`define ACS_ADDR_A_TXH   32'hFFFAC024
`define ACS_ADDR_A_STAT  32'hFFFAC028
`define ACS_ADDR_A_MODE  32'hFFFAC02C
`define ACS_ADDR_B_RXH   32'hFFFAC030
`define ACS_ADDR_B_TXH   32'hFFFAC034
`define ACS_ADDR_B_STAT  32'hFFFAC038
`define ACS_ADDR_CO_RXH  32'hFFFAC040
`define ACS_ADDR_CO_TXH  32'hFFFAC044
`define ACS_ADDR_CO_STAT 32'hFFFAC048

`define ACS_BIT_TRANSMIT_READY    0
`define ACS_BIT_TRANSMIT_EMPTY  1
`define ACS_BIT_TRANSMIT_UNDERRUN    2
`define ACS_BIT_RECEIVE_READY    4
`define ACS_BIT_RECEIVE_OVERRUN    5
`define ACS_BIT_A_END_OF_TRANSMISSION  10
`define ACS_BIT_A_TX_BUFFER_EMPTY 11
`define ACS_BIT_B_END_OF_TRANSMISSION  9
`define ACS_BIT_B_TX_BUFFER_EMPTY 10
`define ACS_BIT_END_OF_RECEPTION    14
`define ACS_BIT_RX_BUFFER_FULL   15
`define ACS_BIT_SIZE     16
`define ACS_BIT_CEM      18
`define ACS_BIT_CEN      21
`define ACS_BIT_CHANNEL_DMA_USE    22

`define ACS_MODE_WMASK   23'h67CC37
`define ACS_MODE_RST     23'h000000
`define ACS_RD_NONE      32'h00000000

`define ACS_SIZE_20      2'h0
`define ACS_SIZE_18      2'h1
`define ACS_SIZE_16      2'h2
`define ACS_SIZE_10      2'h3

`define ACS_SLOT_BITS    5'h14

`endif

// ===== rtl/acs_pkg.sv
/*
  Types for the audio channel status and mode block: the channel index and
  the single packed state record of the block.
  Assumes acs_cfg.svh for every number.
*/
package acs_pkg;

  typedef enum logic [1:0] {ACS_CH_A, ACS_CH_B, ACS_CH_CO} acs_chan_t;

  typedef struct packed {
    logic [22:0]      mode_a;
    logic [2:0]       hold_full;
    logic [2:0][19:0] hold_data;
    logic [2:0][4:0]  shift_cnt;
    logic [2:0]       transmit_underrun;
    logic [2:0]       rx_rdy;
    logic [2:0]       receive_overrun;
    logic [2:0][19:0] rx_data;
    logic [3:0]       end_flag;
    logic [3:0]       buf_flag;
    logic [3:0]       cur_zero_q;
    logic [1:0]       bclk_s;
    logic             bclk_q;
    logic [2:0]       req_s1;
    logic [2:0]       req_s2;
    logic [2:0]       req_q;
    logic [2:0]       rx_s1;
    logic [2:0]       rx_s2;
    logic [2:0]       rx_q;
    logic [19:0]      rxw_s1;
    logic [19:0]      rxw_s2;
    logic             wr_pend;
    logic [31:0]      wr_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic             event_a;
    logic [19:0]      tx_word;
    logic             tx_word_valid;
    acs_chan_t        tx_chan;
  } acs_state_t;

endpackage

// ===== dv/acs_codec_model.sv
/*
  Behavioural codec for the far side of the slot interface. It raises sample
  requests, hands in received words and records every word the block emits.
  Assumes the block samples all of these pins on its own clock.
*/
`timescale 1ns/1ns

module acs_codec_model
(
  input  wire logic        i_sys_clk,
  input  wire logic [19:0] i_tx_word,
  input  wire logic        i_tx_word_valid,
  input  wire logic [1:0]  i_tx_chan,
  output var  logic        o_bit_clk,
  output var  logic [2:0]  o_slot_req,
  output var  logic [2:0]  o_slot_rx,
  output var  logic [19:0] o_rx_word
);
  logic [19:0] got_word;
  logic [1:0]  got_chan;
  int          n_got;

  initial
  begin
    o_bit_clk  = 1'b0;
    o_slot_req = 3'h0;
    o_slot_rx  = 3'h0;
    o_rx_word  = 20'hA5A5A;
    n_got      = 0;
  end

  // the valid strobe stands one cycle only, so the word is caught in that cycle
  always @(posedge i_sys_clk)
  begin
    if (i_tx_word_valid === 1'b1)
    begin
      got_word <= i_tx_word;
      got_chan <= i_tx_chan;
      n_got    <= n_got + 1;
    end
  end

  // bit clock runs only inside a slot and rests low between slots
  task automatic bits(input int n);
    // keep link edges off the system clock edges
    #3;
    repeat (n)
    begin
      #80 o_bit_clk = 1'b1;
      #80 o_bit_clk = 1'b0;
    end
  endtask

  task automatic req_rise(input int ch);
    #3 o_slot_req[ch] = 1'b1;
  endtask

  task automatic req_fall(input int ch);
    o_slot_req[ch] = 1'b0;
    #80;
  endtask

  task automatic slot(input int ch);
    req_rise(ch);
    bits(24);
    req_fall(ch);
  endtask

  task automatic rx(input int ch, input logic [19:0] w);
    #3 o_rx_word = w;
    #40 o_slot_rx[ch] = 1'b1;
    bits(1);
    // released data line shows the inverse, never a stale copy
    o_rx_word = ~w;
    o_slot_rx[ch] = 1'b0;
    #80;
  endtask
endmodule

// ===== dv/ac97_channel_status_mode_bench.sv
/*
  Self-checking bench of the audio channel status and mode block: register
  traffic, DMA counter flags, slot emission and reception through a codec model.
  Assumes acs_cfg.svh for addresses; the bus slave answers with zero wait states.
*/
`timescale 1ns/1ns
`include "acs_cfg.svh"

module ac97_channel_status_mode_bench;
  logic        clk;
  logic        nrst;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        variable_rate_mode;
  logic [15:0] cnt [8];
  logic [3:0]  cwr;
  logic        bclk;
  logic [2:0]  sreq;
  logic [2:0]  srx;
  logic [19:0] rxw;
  logic [19:0] txw;
  logic        txv;
  logic [1:0]  txc;
  logic        evt;
  logic [31:0] rd;
  logic [31:0] d;
  int          n_errors;
  int          n_checks;
  int          ng;

  acs_status dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_variable_rate_mode(variable_rate_mode),
    .i_chan_a_tx_counter(cnt[0]), .i_chan_a_tx_next_counter(cnt[1]), .i_chan_a_rx_counter(cnt[2]),
    .i_chan_a_rx_next_counter(cnt[3]), .i_chan_b_tx_counter(cnt[4]), .i_chan_b_tx_next_counter(cnt[5]),
    .i_chan_b_rx_counter(cnt[6]), .i_chan_b_rx_next_counter(cnt[7]), .i_chan_a_tx_counter_wr(cwr[0]),
    .i_chan_a_rx_counter_wr(cwr[1]), .i_chan_b_tx_counter_wr(cwr[2]), .i_chan_b_rx_counter_wr(cwr[3]),
    .i_bit_clk(bclk), .i_slot_req(sreq), .i_slot_rx(srx), .i_rx_word(rxw), .o_tx_word(txw),
    .o_tx_word_valid(txv), .o_tx_chan(txc), .o_chan_a_event(evt));

  acs_codec_model codec_u (.i_sys_clk(clk), .i_tx_word(txw), .i_tx_word_valid(txv), .i_tx_chan(txc),
    .o_bit_clk(bclk), .o_slot_req(sreq), .o_slot_rx(srx), .o_rx_word(rxw));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic set_cnt(input logic [7:0] zero);
    @(posedge clk);
    for (int k = 0; k < 8; k++)
      cnt[k] <= zero[k] ? 16'h0000 : 16'h0001;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse_wr();
    @(posedge clk);
    cwr <= 4'hF;
    @(posedge clk);
    cwr <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] dma_exp(input logic [15:0] c0, c1, c2, c3, input int tb);
    return (32'(c0 == 16'h0 && c1 == 16'h0) << tb) | (32'(c2 == 16'h0 && c3 == 16'h0) << 15);
  endfunction

  function automatic logic [19:0] slot_exp(input logic [1:0] s, input logic [31:0] w, input logic channel_endian_mode);
    logic [31:0] v;
    int          n;
    v = channel_endian_mode ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    n = (s == `ACS_SIZE_20) ? 20 : (s == `ACS_SIZE_18) ? 18 : (s == `ACS_SIZE_16) ? 16 : 10;
    v = (v & ((32'h1 << n) - 32'h1)) << (20 - n);
    return v[19:0];
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // generous bound: the whole run needs well under a fifth of it
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial
  begin
    {nrst, hsel, hwrite, variable_rate_mode, htrans, cwr} = '0;
    hsize  = 3'h2;
    haddr  = 32'h0;
    hwdata = 32'h0;
    n_errors = 0;
    n_checks = 0;
    for (int k = 0; k < 8; k++)
      cnt[k] = 16'h0001;
    void'($urandom(32'h713D));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rdm(`ACS_ADDR_A_MODE, 32'hFFFFFFFF, 32'h0);
    rdm(32'hFFFAC060, 32'hFFFFFFFF, 32'h0);
    repeat (4)
    begin
      d = $urandom;
      bus(1'b1, `ACS_ADDR_A_MODE, d);
      rdm(`ACS_ADDR_A_MODE, 32'hFFFFFFFF, {9'h0, d[22:0] & `ACS_MODE_WMASK});
    end
    bus(1'b1, `ACS_ADDR_A_MODE, 32'h00400000);
    repeat (6)
    begin
      @(posedge clk);
      // random counter writes and rate mode: buffer flags must not care
      cwr <= 4'($urandom);
      variable_rate_mode <= 1'($urandom);
      for (int k = 0; k < 8; k++)
        cnt[k] <= ($urandom & 1) ? 16'h0000 : 16'($urandom | 1);
      @(posedge clk);
      cwr <= 4'h0;
      repeat (2) @(posedge clk);
      rdm(`ACS_ADDR_A_STAT, 32'h8800, dma_exp(cnt[0], cnt[1], cnt[2], cnt[3], 11));
      rdm(`ACS_ADDR_B_STAT, 32'h8400, dma_exp(cnt[4], cnt[5], cnt[6], cnt[7], 10));
    end
    set_cnt(8'h00);
    pulse_wr();
    rdm(`ACS_ADDR_A_STAT, 32'h4400, 32'h0);
    rdm(`ACS_ADDR_B_STAT, 32'h4200, 32'h0);
    set_cnt(8'h55);
    rdm(`ACS_ADDR_A_STAT, 32'hCC00, 32'h4400);
    rdm(`ACS_ADDR_B_STAT, 32'hC600, 32'h4200);
    pulse_wr();
    rdm(`ACS_ADDR_A_STAT, 32'h4400, 32'h0);
    rdm(`ACS_ADDR_B_STAT, 32'h4200, 32'h0);
    set_cnt(8'hFF);
    rdm(`ACS_ADDR_A_STAT, 32'hCC00, 32'h8800);
    bus(1'b1, `ACS_ADDR_A_MODE, 32'h0);
    rdm(`ACS_ADDR_A_STAT, 32'hCC00, 32'h0);
    rdm(`ACS_ADDR_B_STAT, 32'h8400, 32'h8400);
    // four sizes plain, then full size with the endian swap
    for (int s = 0; s < 5; s++)
    begin
      d = $urandom;
      bus(1'b1, `ACS_ADDR_A_MODE, {10'h0, 1'b1, 2'h0, s == 4, 2'(s), 16'h0});
      bus(1'b1, `ACS_ADDR_A_TXH, d);
      rdm(`ACS_ADDR_A_STAT, 32'h3, 32'h0);
      ng = codec_u.n_got;
      codec_u.req_rise(0);
      codec_u.bits(4);
      chk(32'(codec_u.n_got - ng), 32'h1);
      chk({12'h0, codec_u.got_word}, {12'h0, slot_exp(2'(s), d, s == 4)});
      rdm(`ACS_ADDR_A_STAT, 32'h3, 32'h1);
      codec_u.bits(20);
      codec_u.req_fall(0);
      rdm(`ACS_ADDR_A_STAT, 32'h3, 32'h3);
    end
    variable_rate_mode <= 1'b1;
    codec_u.slot(0);
    chk({12'h0, codec_u.got_word}, 32'h0);
    rdm(`ACS_ADDR_A_STAT, 32'h4, 32'h4);
    rdm(`ACS_ADDR_A_STAT, 32'h4, 32'h0);
    variable_rate_mode <= 1'b0;
    codec_u.slot(0);
    rdm(`ACS_ADDR_A_STAT, 32'h4, 32'h0);
    d = $urandom;
    bus(1'b1, `ACS_ADDR_B_TXH, d);
    codec_u.slot(1);
    chk({10'h0, codec_u.got_chan, codec_u.got_word}, {10'h0, 2'h1, d[19:0]});
    bus(1'b1, `ACS_ADDR_A_MODE, 32'h00200001);
    repeat (3) @(posedge clk);
    chk(32'(evt), 32'h1);
    bus(1'b1, `ACS_ADDR_A_MODE, 32'h00200000);
    repeat (3) @(posedge clk);
    chk(32'(evt), 32'h0);
    bus(1'b1, `ACS_ADDR_A_MODE, 32'h0);
    ng = codec_u.n_got;
    codec_u.slot(0);
    codec_u.rx(0, d[19:0]);
    chk(32'(codec_u.n_got - ng), 32'h0);
    rdm(`ACS_ADDR_A_STAT, 32'h10, 32'h0);
    codec_u.rx(2, d[19:0]);
    rdm(`ACS_ADDR_CO_STAT, 32'h30, 32'h10);
    rdm(`ACS_ADDR_CO_RXH, 32'hFFFFF, {12'h0, d[19:0]});
    rdm(`ACS_ADDR_CO_STAT, 32'h30, 32'h0);
    codec_u.rx(2, ~d[19:0]);
    codec_u.rx(2, d[19:0]);
    bus(1'b0, `ACS_ADDR_A_MODE, 32'h0);
    rdm(`ACS_ADDR_CO_STAT, 32'h30, 32'h30);
    rdm(`ACS_ADDR_CO_STAT, 32'h20, 32'h0);
    finish_test();
  end
endmodule
